// File: breaker_failure_logic.sv
// breaker failure decision logic: per-phase backup and retrip timing chains
// Function
// - rising start edges launch per-phase timers
// - separate backup and retrip chains per start
// - current mode ignores breaker-closed inputs
// - contact mode uses only breaker-closed inputs
// - combined mode resets only when fully clear
// - off mode disables everything, no outputs
// - backup expiry with fault asserts backup trip
// - trips last at least pulse duration
// - retrip per faulted phase only when enabled
// - block input suppresses all trips
// - phase and residual over-threshold flags
// - residual start supervised by residual flag, or by common closed input in contact modes
// - common variant gives backup trip only
// - backup trip aims at backup breakers
// - backup delay 100 to 60000 ms
// - retrip delay 0 to 1000 ms
// - pulse duration 0 to 60000 ms
`timescale 1ns/1ps
module breaker_failure_logic
  import breaker_failure_pkg::*;
#(
  parameter breaker_failure_pkg::variant_t VARIANT = breaker_failure_pkg::SINGLE_POLE_VARIANT,
  parameter int TICK_COUNT = breaker_failure_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire breaker_failure_pkg::config_t cfg,
  input wire breaker_failure_pkg::start_t startIn,
  input wire breaker_failure_pkg::closed_t closedIn,
  input wire breaker_failure_pkg::over_t overIn,
  input wire logic blockIn,
  output logic backupTripOut,
  output logic [2:0] retripOut
);
  import breaker_failure_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // inputs come from the relay's own logic but are treated as async pins
  localparam int NSYNC = 5 + 4 + 4 + 1;
  logic [NSYNC-1:0] syncA_q, syncB_q;
  always_ff @(posedge clk) begin
    syncA_q <= {startIn, closedIn, overIn, blockIn};
    syncB_q <= syncA_q;
  end
  start_t st;
  closed_t cl;
  over_t ov;
  logic blk;
  assign {st, cl, ov, blk} = syncB_q;

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  logic [15:0] tickCnt_q, tickCnt_d;
  logic tick;
  assign tick = (tickCnt_q == 16'(TICK_COUNT - 1));
  always_comb begin
    tickCnt_d = tick ? 16'h0000 : tickCnt_q + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (reset) tickCnt_q <= 16'h0000;
    else tickCnt_q <= tickCnt_d;
  end

  // ----------------------------------------
  // settings clamp and enables
  // ----------------------------------------
  logic [MS_WIDTH-1:0] backupMs, retripMs, pulseMs;
  always_comb begin
    backupMs = cfg.backupDelayMs;
    if (backupMs < BACKUP_DELAY_MIN_MS) backupMs = BACKUP_DELAY_MIN_MS;
    if (backupMs > BACKUP_DELAY_MAX_MS) backupMs = BACKUP_DELAY_MAX_MS;
    retripMs = (cfg.retripDelayMs > RETRIP_DELAY_MAX_MS) ? RETRIP_DELAY_MAX_MS
                                                          : cfg.retripDelayMs;
    pulseMs = (cfg.pulseMs > PULSE_MAX_MS) ? PULSE_MAX_MS : cfg.pulseMs;
  end
  logic active;
  assign active = (cfg.mode != MODE_OFF) && !blk;
  logic useCur, useCon;
  assign useCur = (cfg.mode == MODE_CURRENT) || (cfg.mode == MODE_CURRENT_CONTACT);
  assign useCon = (cfg.mode == MODE_CONTACT) || (cfg.mode == MODE_CURRENT_CONTACT);

  // ----------------------------------------
  // start edges, sampled on the tick
  // ----------------------------------------
  // channels 0..2 phases, 3 residual
  logic [3:0] startLvl, startPrev_q, startPrev_d, startEdge, fault;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      startLvl[i] = st.general | (VARIANT == SINGLE_POLE_VARIANT ? st.phase[i] : 1'b0);
    end
    startLvl[3] = st.residual;
    startPrev_d = tick ? startLvl : startPrev_q;
  end
  assign startEdge = tick ? (startLvl & ~startPrev_q) : 4'h0;
  always_ff @(posedge clk) begin
    if (reset) startPrev_q <= 4'h0;
    else startPrev_q <= startPrev_d;
  end

  // ----------------------------------------
  // failure condition per channel
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gPhaseFault
      logic closedPh;
      assign closedPh = (VARIANT == SINGLE_POLE_VARIANT) ? cl.phase[g] : cl.common;
      // fault persists while any monitored condition says not clear
      assign fault[g] = (useCur & ov.phase[g]) | (useCon & closedPh);
    end
  endgenerate
  assign fault[3] = (useCur & ov.residual) | (useCon & cl.common);

  // ----------------------------------------
  // timing chains
  // ----------------------------------------
  logic [3:0] buRun_q, buRun_d, rtRun_q, rtRun_d, buExp, rtExp;
  logic [MS_WIDTH-1:0] buCnt_q [4], buCnt_d [4], rtCnt_q [4], rtCnt_d [4];
  generate
    for (g = 0; g < 4; g++) begin : gChain
      always_comb begin
        buRun_d[g] = buRun_q[g];
        buCnt_d[g] = buCnt_q[g];
        rtRun_d[g] = rtRun_q[g];
        rtCnt_d[g] = rtCnt_q[g];
        buExp[g] = 1'b0;
        rtExp[g] = 1'b0;
        if (!active) begin
          buRun_d[g] = 1'b0;
          rtRun_d[g] = 1'b0;
        end else if (startEdge[g]) begin
          buRun_d[g] = 1'b1;
          buCnt_d[g] = '0;
          rtRun_d[g] = 1'b1;
          rtCnt_d[g] = '0;
        end else if (tick) begin
          if (buRun_q[g]) begin
            if (!fault[g]) buRun_d[g] = 1'b0;
            else if (buCnt_q[g] + 16'h0001 >= backupMs) begin
              buRun_d[g] = 1'b0;
              buExp[g] = 1'b1;
            end else buCnt_d[g] = buCnt_q[g] + 16'h0001;
          end
          if (rtRun_q[g]) begin
            if (!fault[g]) rtRun_d[g] = 1'b0;
            else if (rtCnt_q[g] + 16'h0001 >= retripMs) begin
              rtRun_d[g] = 1'b0;
              rtExp[g] = 1'b1;
            end else rtCnt_d[g] = rtCnt_q[g] + 16'h0001;
          end
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          buRun_q[g] <= 1'b0;
          rtRun_q[g] <= 1'b0;
          buCnt_q[g] <= '0;
          rtCnt_q[g] <= '0;
        end else begin
          buRun_q[g] <= buRun_d[g];
          rtRun_q[g] <= rtRun_d[g];
          buCnt_q[g] <= buCnt_d[g];
          rtCnt_q[g] <= rtCnt_d[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // output pulse stretchers
  // ----------------------------------------
  // index 0 backup, 1..3 retrip phases
  logic [3:0] trip_q, trip_d, fire;
  logic [MS_WIDTH-1:0] hold_q [4], hold_d [4];
  assign fire[0] = |buExp;
  assign fire[3:1] = (VARIANT == SINGLE_POLE_VARIANT && cfg.retripEnable)
                     ? rtExp[2:0] : 3'h0;
  generate
    for (g = 0; g < 4; g++) begin : gPulse
      always_comb begin
        trip_d[g] = trip_q[g];
        hold_d[g] = hold_q[g];
        if (!active) begin
          trip_d[g] = 1'b0;
          hold_d[g] = '0;
        end else if (fire[g]) begin
          trip_d[g] = 1'b1;
          hold_d[g] = '0;
        end else if (tick && trip_q[g]) begin
          // condition-independent: stretched only by the pulse setting
          if (hold_q[g] + 16'h0001 >= pulseMs) trip_d[g] = 1'b0;
          else hold_d[g] = hold_q[g] + 16'h0001;
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          trip_q[g] <= 1'b0;
          hold_q[g] <= '0;
        end else begin
          trip_q[g] <= trip_d[g];
          hold_q[g] <= hold_d[g];
        end
      end
    end
  endgenerate
  assign backupTripOut = trip_q[0];
  assign retripOut = trip_q[3:1];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence sBackupFire;
    active && tick && buRun_q[0] && fault[0] && (buCnt_q[0] + 16'h0001 >= backupMs);
  endsequence
  AST_OFF_NO_OUT: assert property (@(posedge clk) disable iff (reset)
    (cfg.mode == MODE_OFF) |=> !backupTripOut && retripOut == 3'h0)
    else $error("trip output while off");
  AST_BLOCK_NO_OUT: assert property (@(posedge clk) disable iff (reset)
    $past(blk) |-> !backupTripOut && retripOut == 3'h0)
    else $error("trip output while blocked");
  AST_BACKUP_FIRE: assert property (@(posedge clk) disable iff (reset)
    sBackupFire |=> backupTripOut)
    else $error("backup trip missing after expiry");
  AST_PULSE_HOLD: assert property (@(posedge clk) disable iff (reset)
    $fell(backupTripOut) && $past(active) |-> $past(hold_q[0]) + 16'h0001 >= pulseMs)
    else $error("backup trip pulse too short");
  AST_NO_RETRIP_OFF: assert property (@(posedge clk) disable iff (reset)
    !cfg.retripEnable && $past(!cfg.retripEnable) |-> !$rose(|retripOut))
    else $error("retrip while disabled");
  AST_COMMON_NO_RETRIP: assert property (@(posedge clk) disable iff (reset)
    VARIANT == COMMON_PHASE_VARIANT |-> retripOut == 3'h0)
    else $error("retrip in common variant");
  AST_EDGE_STARTS: assert property (@(posedge clk) disable iff (reset)
    active && startEdge[0] |=> buRun_q[0] && rtRun_q[0] && buCnt_q[0] == '0)
    else $error("timer not started on edge");
  AST_CLEAR_CANCELS: assert property (@(posedge clk) disable iff (reset)
    active && tick && !startEdge[1] && !fault[1] |=> !buRun_q[1])
    else $error("timer not cancelled when clear");
  AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (reset)
    tick |=> !tick)
    else $error("tick too frequent");

endmodule // breaker_failure_logic

// File: breaker_failure_pkg.sv
// shared types, modes and timing constants of the breaker failure decision logic
package breaker_failure_pkg;

  // ----------------------------------------
  // operation modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CURRENT,
    MODE_CONTACT,
    MODE_CURRENT_CONTACT
  } oper_mode_t;

  typedef enum logic {
    COMMON_PHASE_VARIANT,
    SINGLE_POLE_VARIANT
  } variant_t;

  // ----------------------------------------
  // timing settings, all in milliseconds
  // ----------------------------------------
  localparam int MS_WIDTH = 16;
  localparam logic [MS_WIDTH-1:0] BACKUP_DELAY_MIN_MS = 16'd100;
  localparam logic [MS_WIDTH-1:0] BACKUP_DELAY_MAX_MS = 16'd60000;
  localparam logic [MS_WIDTH-1:0] BACKUP_DELAY_DEFAULT_MS = 16'd1000;
  localparam logic [MS_WIDTH-1:0] RETRIP_DELAY_MAX_MS = 16'd1000;
  localparam logic [MS_WIDTH-1:0] RETRIP_DELAY_DEFAULT_MS = 16'd100;
  localparam logic [MS_WIDTH-1:0] PULSE_MAX_MS = 16'd60000;
  localparam logic [MS_WIDTH-1:0] PULSE_DEFAULT_MS = 16'd100;

  // ----------------------------------------
  // clock and millisecond tick
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MS_PS = 1000000000;
  localparam int TICK_CYCLES = MS_PS / CLK_PERIOD_PS;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic general;
    logic [2:0] phase;
    logic residual;
  } start_t;

  typedef struct packed {
    logic common;
    logic [2:0] phase;
  } closed_t;

  typedef struct packed {
    logic [2:0] phase;
    logic residual;
  } over_t;

  typedef struct packed {
    oper_mode_t mode;
    logic retripEnable;
    logic [MS_WIDTH-1:0] backupDelayMs;
    logic [MS_WIDTH-1:0] retripDelayMs;
    logic [MS_WIDTH-1:0] pulseMs;
  } config_t;

endpackage

// File: bf_partner.sv
// far-side model: breaker poles, auxiliary contacts and fault current
`timescale 1ns/1ps
module bf_partner (
  input wire logic clk,
  input wire breaker_failure_pkg::start_t startIn,
  input wire logic [3:0] stuck,
  input wire logic auxStuck,
  input wire logic [7:0] openCycles,
  output breaker_failure_pkg::closed_t closedIn,
  output breaker_failure_pkg::over_t overIn
);
  import breaker_failure_pkg::*;
  logic tripCmd;
  logic opened;
  logic [7:0] cnt_q;
  logic [2:0] cl;
  // ----------------------------------------
  // breaker opening after a trip command
  // ----------------------------------------
  // any protection trip reaches the block as the start the user wired
  assign tripCmd = |startIn;
  assign opened = (cnt_q == openCycles);
  always_ff @(posedge clk) begin
    if (!tripCmd) begin
      cnt_q <= 8'h00;
    end else if (!opened) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // ----------------------------------------
  // contacts and current flags
  // ----------------------------------------
  // stuck pole keeps current and contact, aux fault keeps the contact only
  assign cl = {3{!opened | auxStuck}} | stuck[2:0];
  assign closedIn = '{common: |cl, phase: cl};
  assign overIn = '{phase: {3{tripCmd}} & ({3{!opened}} | stuck[2:0]),
                    residual: tripCmd & (!opened | stuck[3])};
endmodule // bf_partner

// File: tb.sv
// self-checking testbench of the breaker failure decision logic
`timescale 1ns/1ps
module tb;
  import breaker_failure_pkg::*;
  localparam int T = 4;
  localparam start_t GEN = 5'h10;
  localparam start_t PH1 = 5'h02;
  localparam start_t RES = 5'h01;
  logic clk, reset, blockIn, backupTripOut, auxStuck, commonBackup;
  logic [2:0] retripOut, commonRetrip;
  logic [3:0] stuck;
  logic [7:0] openCycles;
  config_t cfg;
  start_t startIn;
  closed_t closedIn;
  over_t overIn;
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;
  logic [31:0] rs = 32'h00000002;

  breaker_failure_logic #(.TICK_COUNT(T)) u_dut (.clk(clk), .reset(reset), .cfg(cfg),
    .startIn(startIn), .closedIn(closedIn), .overIn(overIn), .blockIn(blockIn),
    .backupTripOut(backupTripOut), .retripOut(retripOut));
  breaker_failure_logic #(.VARIANT(COMMON_PHASE_VARIANT), .TICK_COUNT(T)) u_common (
    .clk(clk), .reset(reset), .cfg(cfg), .startIn(startIn), .closedIn(closedIn),
    .overIn(overIn), .blockIn(blockIn), .backupTripOut(commonBackup),
    .retripOut(commonRetrip));
  bf_partner u_far (.clk(clk), .startIn(startIn), .stuck(stuck), .auxStuck(auxStuck),
    .openCycles(openCycles), .closedIn(closedIn), .overIn(overIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a hang is cut short well above the ~11k cycles the cases need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      $display("[ERR] %0t timeout", $time);
      reportAndStop();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // bit 3 residual channel, bits 2:0 phase channels still faulted at expiry
  function automatic logic [3:0] fault(oper_mode_t m, start_t st, logic [3:0] sk, logic ax);
    logic cur, con;
    logic [2:0] s;
    cur = (m == MODE_CURRENT) || (m == MODE_CURRENT_CONTACT);
    con = (m == MODE_CONTACT) || (m == MODE_CURRENT_CONTACT);
    s = st.phase | {3{st.general}};
    return {st.residual & ((cur & sk[3]) | (con & (|sk[2:0] | ax))),
            s & ((cur ? sk[2:0] : 3'h0) | (con ? (sk[2:0] | {3{ax}}) : 3'h0))};
  endfunction
  task automatic check_bits(input logic [2:0] got, input logic [2:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic check_span(input int got, input int lo, input int hi, input string what);
    nChecks++;
    if (got < lo || got > hi) begin
      failCount++;
      $display("[ERR] %0t %s %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic run_case(input oper_mode_t m, input logic re, input start_t st,
                          input logic [3:0] sk, input logic ax, input logic blk);
    logic [3:0] f;
    logic expB, expC, seenCB;
    logic [2:0] expR, seenR, seenC;
    start_t stc;
    int pl, rt, riseB, highB, riseR;
    f = fault(m, st, sk, ax);
    expB = (m != MODE_OFF) && !blk && (|f);
    expR = (expB && re) ? f[2:0] : 3'h0;
    // common variant never sees the phase starts
    stc = st;
    stc.phase = 3'h0;
    expC = (m != MODE_OFF) && !blk && (|fault(m, stc, sk, ax));
    seenCB = 1'b0;
    pl = 1 + rnd() % 20;
    rt = 15 + rnd() % 30;
    cfg = '{mode: m, retripEnable: re, backupDelayMs: 16'h0064, retripDelayMs: 16'(rt),
            pulseMs: 16'(pl)};
    openCycles = 8'(4 + rnd() % 36);
    stuck = sk;
    auxStuck = ax;
    blockIn = blk;
    startIn = st;
    riseB = -1;
    riseR = -1;
    highB = 0;
    seenR = 3'h0;
    seenC = 3'h0;
    for (int n = 0; n < (108 + pl) * T; n++) begin
      @(posedge clk);
      #2;
      if (backupTripOut === 1'b1) begin
        if (riseB < 0) riseB = n;
        highB++;
      end
      if (retripOut !== 3'h0 && riseR < 0) riseR = n;
      seenR = seenR | retripOut;
      seenC = seenC | commonRetrip;
      if (commonBackup === 1'b1) seenCB = 1'b1;
    end
    check_bits({2'b00, riseB >= 0}, {2'b00, expB}, "backup");
    check_bits(seenR, expR, "retrip");
    check_bits(seenC, 3'h0, "common retrip");
    check_bits({2'b00, seenCB}, {2'b00, expC}, "common backup");
    if (expB) begin
      check_span(riseB, 99 * T, 102 * T + 8, "backup delay");
      check_span(highB, pl * T, pl * T, "pulse");
    end
    if (expR != 3'h0) check_span(riseR, (rt - 1) * T, (rt + 2) * T + 8, "retrip delay");
    startIn = '0;
    stuck = 4'h0;
    auxStuck = 1'b0;
    blockIn = 1'b0;
    repeat (30 * T) @(posedge clk);
    #2;
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cfg = '{mode: MODE_OFF, retripEnable: 1'b0, backupDelayMs: 16'h0064,
            retripDelayMs: 16'h0000, pulseMs: 16'h0000};
    startIn = '0;
    stuck = 4'h0;
    auxStuck = 1'b0;
    openCycles = 8'h08;
    blockIn = 1'b0;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #2;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    run_case(MODE_CURRENT, 1'b1, GEN, 4'h2, 1'b0, 1'b0);
    run_case(MODE_CURRENT, 1'b1, PH1, 4'h3, 1'b0, 1'b0);
    run_case(MODE_CURRENT, 1'b0, GEN, 4'h7, 1'b0, 1'b0);
    run_case(MODE_CURRENT, 1'b1, GEN, 4'h0, 1'b1, 1'b0);
    run_case(MODE_CONTACT, 1'b1, GEN, 4'h0, 1'b1, 1'b0);
    run_case(MODE_CONTACT, 1'b1, GEN, 4'h0, 1'b0, 1'b0);
    run_case(MODE_CURRENT_CONTACT, 1'b1, GEN, 4'h0, 1'b1, 1'b0);
    run_case(MODE_OFF, 1'b1, GEN, 4'h7, 1'b1, 1'b0);
    run_case(MODE_CURRENT, 1'b1, GEN, 4'h7, 1'b0, 1'b1);
    run_case(MODE_CURRENT, 1'b1, RES, 4'h8, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      run_case(oper_mode_t'(2'(1 + rnd() % 3)), 1'(rnd()), 5'(rnd()), 4'(rnd()), 1'(rnd()),
               1'b0);
    end
    reportAndStop();
  end
endmodule // tb
